// ===== verilog/ddrsp_pkg.sv
/*
  Shared constants and types for the burst SRAM port: write-phase states, data-width
  choices, strap and timing figures.
  Assumes every user writes ddrsp_pkg::name; nothing is imported.
*/
package ddrsp_pkg;

  // write-phase sequencer
  typedef enum logic [1:0] {
    WR_IDLE  = 2'b00,
    WR_WORD0 = 2'b01,
    WR_WORD1 = 2'b10
  } ddrsp_wr_state_type;

  localparam int DATA_W_DEFAULT = 18;
  localparam int ADDR_W_DEFAULT = 4;
  localparam int BURST_LEN      = 2;
  localparam int SYNC_STAGES    = 2;
  localparam int FIFO_DEPTH     = 2;

  // reset values and burst word selects
  localparam logic RST_OE         = 1'b0;
  localparam logic RST_SINGLE_CLK = 1'b0;
  localparam logic BURST_FIRST    = 1'b0;
  localparam logic BURST_SECOND   = 1'b1;

  // lanes per word for each supported width; 0 marks an illegal width
  function automatic int lanes_of(input int data_w);
    case (data_w)
      8:       lanes_of = 2;
      9:       lanes_of = 1;
      18:      lanes_of = 2;
      36:      lanes_of = 4;
      default: lanes_of = 0;
    endcase
  endfunction : lanes_of

endpackage : ddrsp_pkg

// ===== verilog/ddrsp_fifo2.sv
/*
  Small valid/ready buffer holding read words between the array and the output
  register, so a missing output clock edge never drops a word.
  Assumes one clock, synchronous active-low reset, DEPTH a power of two.
*/
module ddrsp_fifo2 #(
  parameter int W     = 18,
  parameter int DEPTH = ddrsp_pkg::FIFO_DEPTH
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("fifo depth must be a power of two, at least two");
    end
  end

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0]   count_r;
  logic          push;
  logic          pop;

  assign o_in_ready  = (count_r != (PW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem_r[rd_ptr_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // storage written at the write pointer
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers and occupancy; simultaneous push and pop keep the count
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : ddrsp_fifo2

// ===== verilog/ddrsp_port.sv
/*
  Command, burst and data logic of a separate-input/output double-rate burst SRAM:
  command decode, write capture with per-word lane masks, posted writes, read burst
  through a two-entry buffer, strap-selected output timing, tri-state control.
  Assumes all pins are asynchronous to i_sys_clk and much slower than it, so each
  strobe edge is seen as one synchronised event; strobes of one phase never coincide.
*/
module ddrsp_port #(
  parameter int DATA_W = ddrsp_pkg::DATA_W_DEFAULT,
  parameter int ADDR_W = ddrsp_pkg::ADDR_W_DEFAULT
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_k,
  input  wire logic              i_k_n,
  input  wire logic              i_c,
  input  wire logic              i_c_n,
  input  wire logic              i_load_select_n,
  input  wire logic              i_rw,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_d,
  input  wire logic [3:0]        i_byte_lane_write_n,
  output logic [DATA_W-1:0]      o_q,
  output logic                   o_q_oe
);
  localparam int LANES  = ddrsp_pkg::lanes_of(DATA_W);
  localparam int LANE_W = (LANES > 0) ? DATA_W / LANES : 1;
  localparam int DEPTH  = 2 ** (ADDR_W + 1);
  localparam int PIN_W  = 6 + ADDR_W + DATA_W + 4;

  initial begin
    if (LANES == 0) begin
      $error("data width must be 8, 9, 18 or 36");
    end
    if (ADDR_W < 1 || ADDR_W > 20) begin
      $error("address width out of range");
    end
  end

  // expand active-low lane selects to a per-bit write enable
  function automatic logic [DATA_W-1:0] lane_en(input logic [3:0] sel_n);
    lane_en = '0;
    for (int i = 0; i < LANES; i++) begin
      lane_en[i*LANE_W +: LANE_W] = {LANE_W{~sel_n[i]}};
    end
  endfunction : lane_en

  // two-stage synchroniser for every pin; stage one feeds only stage two
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  always_ff @(posedge i_sys_clk) begin
    pin_s1_r <= {i_k, i_k_n, i_c, i_c_n, i_load_select_n, i_rw, i_addr, i_d,
                 i_byte_lane_write_n};
    pin_s2_r <= pin_s1_r;
  end

  logic              k_s;
  logic              kn_s;
  logic              c_s;
  logic              cn_s;
  logic              ld_n_s;
  logic              rw_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] d_s;
  logic [3:0]        sel_n_s;
  assign {k_s, kn_s, c_s, cn_s, ld_n_s, rw_s, addr_s, d_s, sel_n_s} = pin_s2_r;

  // edge detection on the second stage only
  logic [3:0] clk_prev_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      clk_prev_r <= 4'hf;
    end else begin
      clk_prev_r <= {k_s, kn_s, c_s, cn_s};
    end
  end

  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  assign k_rise  = k_s  && !clk_prev_r[3];
  assign kn_rise = kn_s && !clk_prev_r[2];
  assign c_rise  = c_s  && !clk_prev_r[1];
  assign cn_rise = cn_s && !clk_prev_r[0];

  // strap caught once after reset release, never altered afterwards
  logic single_clk_r;
  logic strap_done_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      single_clk_r <= ddrsp_pkg::RST_SINGLE_CLK;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      single_clk_r <= c_s && cn_s;
      strap_done_r <= 1'b1;
    end
  end

  // output timing edges: C and C# normally, K and K# when strapped
  logic out_pos;
  logic out_neg;
  assign out_pos = single_clk_r ? k_rise  : c_rise;
  assign out_neg = single_clk_r ? kn_rise : cn_rise;

  logic wr_cmd;
  logic rd_cmd;
  assign wr_cmd = k_rise && !ld_n_s && !rw_s;
  assign rd_cmd = k_rise && !ld_n_s && rw_s;

  // array, posted-write holding registers and write sequencer
  logic [DATA_W-1:0] mem_r [DEPTH];
  ddrsp_pkg::ddrsp_wr_state_type wr_state_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [ADDR_W-1:0] wr_next_addr_r;
  logic              wr_next_r;
  logic [DATA_W-1:0] wr_d0_r;
  logic [3:0]        wr_m0_r;
  logic              pend_valid_r;
  logic [ADDR_W-1:0] pend_addr_r;
  logic [DATA_W-1:0] pend_d0_r;
  logic [DATA_W-1:0] pend_d1_r;
  logic [3:0]        pend_m0_r;
  logic [3:0]        pend_m1_r;
  logic              commit;
  assign commit = wr_cmd && pend_valid_r;

  // write phases: address at t, word0 at K rise t+1, word1 at K# rise t+1
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      wr_state_r <= ddrsp_pkg::WR_IDLE;
      wr_next_r  <= 1'b0;
    end else begin
      unique case (wr_state_r)
        ddrsp_pkg::WR_IDLE: begin
          if (wr_cmd) begin
            wr_state_r <= ddrsp_pkg::WR_WORD0;
          end
        end
        ddrsp_pkg::WR_WORD0: begin
          if (k_rise) begin
            wr_state_r <= ddrsp_pkg::WR_WORD1;
            wr_next_r  <= wr_cmd;
          end
        end
        ddrsp_pkg::WR_WORD1: begin
          if (kn_rise) begin
            wr_state_r <= wr_next_r ? ddrsp_pkg::WR_WORD0 : ddrsp_pkg::WR_IDLE;
            wr_next_r  <= 1'b0;
          end
        end
        default: wr_state_r <= ddrsp_pkg::WR_IDLE;
      endcase
    end
  end

  // address and word captures; each mask sampled with its own word
  always_ff @(posedge i_sys_clk) begin
    if (wr_cmd && wr_state_r == ddrsp_pkg::WR_IDLE) begin
      wr_addr_r <= addr_s;
    end
    if (wr_cmd && wr_state_r == ddrsp_pkg::WR_WORD0) begin
      wr_next_addr_r <= addr_s;
    end
    if (k_rise && wr_state_r == ddrsp_pkg::WR_WORD0) begin
      wr_d0_r <= d_s;
      wr_m0_r <= sel_n_s;
    end
    if (kn_rise && wr_state_r == ddrsp_pkg::WR_WORD1 && wr_next_r) begin
      wr_addr_r <= wr_next_addr_r;
    end
  end

  // posted write: held until a write command commits it or the next write's word1 replaces it
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      pend_valid_r <= 1'b0;
    end else if (kn_rise && wr_state_r == ddrsp_pkg::WR_WORD1) begin
      pend_valid_r <= 1'b1;
      pend_addr_r  <= wr_addr_r;
      pend_d0_r    <= wr_d0_r;
      pend_d1_r    <= d_s;
      pend_m0_r    <= wr_m0_r;
      pend_m1_r    <= sel_n_s;
    end else if (commit) begin
      pend_valid_r <= 1'b0;
    end
  end

  // array update, lane by lane; a high select keeps the stored lane
  for (genvar g = 0; g < ddrsp_pkg::BURST_LEN; g++) begin : g_word
  end
  always_ff @(posedge i_sys_clk) begin
    if (commit) begin
      mem_r[{pend_addr_r, ddrsp_pkg::BURST_FIRST}] <=
        (mem_r[{pend_addr_r, ddrsp_pkg::BURST_FIRST}] & ~lane_en(pend_m0_r)) |
        (pend_d0_r & lane_en(pend_m0_r));
      mem_r[{pend_addr_r, ddrsp_pkg::BURST_SECOND}] <=
        (mem_r[{pend_addr_r, ddrsp_pkg::BURST_SECOND}] & ~lane_en(pend_m1_r)) |
        (pend_d1_r & lane_en(pend_m1_r));
    end
  end

  // read word with the posted write forwarded, so a read never misses the posted write
  function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a,
                                                input logic                b);
    logic [DATA_W-1:0] en;
    logic [DATA_W-1:0] pd;
    en = b ? lane_en(pend_m1_r) : lane_en(pend_m0_r);
    pd = b ? pend_d1_r : pend_d0_r;
    rd_word = mem_r[{a, b}];
    if (pend_valid_r && pend_addr_r == a) begin
      rd_word = (rd_word & ~en) | (pd & en);
    end
  endfunction : rd_word

  // read burst: word A+0 pushed at K rise t+1, word A+1 at K# rise t+1
  logic              rd_w0_r;
  logic              rd_w1_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic [ADDR_W-1:0] rd_addr1_r;
  logic              push_valid;
  logic              push_ready;
  logic [DATA_W-1:0] push_data;
  logic              push0;
  logic              push1;
  assign push0      = rd_w0_r && k_rise;
  assign push1      = rd_w1_r && kn_rise;
  assign push_valid = push0 || push1;
  assign push_data  = push0 ? rd_word(rd_addr_r, ddrsp_pkg::BURST_FIRST)
                            : rd_word(rd_addr1_r, ddrsp_pkg::BURST_SECOND);

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      rd_w0_r <= 1'b0;
      rd_w1_r <= 1'b0;
    end else begin
      if (push0 && push_ready) begin
        rd_w1_r    <= 1'b1;
        rd_addr1_r <= rd_addr_r;
      end else if (push1 && push_ready) begin
        rd_w1_r <= 1'b0;
      end
      if (rd_cmd) begin
        rd_w0_r   <= 1'b1;
        rd_addr_r <= addr_s;
      end else if (push0 && push_ready) begin
        rd_w0_r <= 1'b0;
      end
    end
  end

  logic              buf_valid;
  logic [DATA_W:0]   buf_word;  // top bit set for the second burst word
  logic              pop_edge;
  logic              pop_now;
  assign pop_edge = out_pos || out_neg;
  // word A+0 leaves only on a negative output edge, A+1 only on a positive one,
  // so the first word never overtakes the negative edge of cycle t+1
  assign pop_now  = buf_valid && (buf_word[DATA_W] ? out_pos : out_neg);

  ddrsp_fifo2 #(
    .W     (DATA_W + 1),
    .DEPTH (ddrsp_pkg::FIFO_DEPTH)
  ) u_rd_buf (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   ({!push0, push_data}),
    .o_out_valid (buf_valid),
    .i_out_ready (pop_now),
    .o_out_data  (buf_word)
  );

  // output register: changes only on output clock edges, else holds
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_q    <= '0;
      o_q_oe <= ddrsp_pkg::RST_OE;
    end else if (pop_now) begin
      o_q    <= buf_word[DATA_W-1:0];
      o_q_oe <= 1'b1;
    end else if (out_pos) begin
      o_q_oe <= 1'b0;
    end
  end  // no edges, no change

  a_powerup_tristate: assert property (@(posedge i_sys_clk)
    !i_nrst |=> !o_q_oe) else $error("outputs driven after reset");
  a_write_word_order: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    wr_state_r == ddrsp_pkg::WR_WORD0 && k_rise |=> wr_state_r == ddrsp_pkg::WR_WORD1)
    else $error("write word order broken");
  a_read_cmd_taken: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    rd_cmd |=> rd_w0_r && rd_addr_r == $past(addr_s)) else $error("read command lost");
  a_burst_second_addr: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    push0 && push_ready |=> rd_w1_r && rd_addr1_r == $past(rd_addr_r))
    else $error("second burst word address wrong");
  a_nop_tristate: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    out_pos && !buf_valid |=> !o_q_oe) else $error("no tri-state after idle edge");
  a_stopped_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !pop_edge && strap_done_r |=> $stable(o_q) && $stable(o_q_oe))
    else $error("outputs moved without a clock edge");
  a_masked_no_write: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    commit && (&pend_m0_r[LANES-1:0]) |=> mem_r[{$past(pend_addr_r), 1'b0}] ==
      $past(mem_r[{pend_addr_r, 1'b0}])) else $error("masked word altered array");
  a_posted_commit: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    commit && !kn_rise |=> !pend_valid_r) else $error("posted write not committed");
  a_strap_fixed: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    strap_done_r |=> $stable(single_clk_r)) else $error("strap changed in operation");

endmodule : ddrsp_port

// ===== verif/ddrsp_ctrl_model.sv
/*
  Behavioural memory controller facing the burst SRAM port: drives strobes, output
  clocks, commands, write data and lane selects, and captures read words in order.
  Assumes one fast system clock; one strobe cycle spans 16 system cycles.
*/
module ddrsp_ctrl_model #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 4
) (
  input  wire logic              i_sys_clk,
  input  wire logic [DATA_W-1:0] i_q,
  input  wire logic              i_q_oe,
  output logic                   o_k,
  output logic                   o_k_n,
  output logic                   o_c,
  output logic                   o_c_n,
  output logic                   o_load_select_n,
  output logic                   o_rw,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [DATA_W-1:0]      o_d,
  output logic [3:0]             o_byte_lane_write_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W:0]   rdq[$];
  logic [DATA_W-1:0] pend_d0, pend_d1;
  logic [3:0]        pend_m0, pend_m1;
  logic              pend, r0, r1, r2;

  // c low at power-up, so never the single-clock strap
  initial begin
    o_k = 1'b0;
    o_k_n = 1'b1;
    o_c = 1'b0;
    o_c_n = 1'b1;
    o_load_select_n = 1'b1;
    o_rw = 1'b0;
    o_addr = '0;
    o_d = '0;
    o_byte_lane_write_n = 4'hf;
    {pend, r0, r1, r2} = 4'h0;
  end

  // one strobe cycle; words of the previous write go out in this one
  task automatic cmd(input logic load_n, input logic rw, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d0, input logic [3:0] m0,
                     input logic [DATA_W-1:0] d1, input logic [3:0] m1);
    {r2, r1, r0} = {r1, r0, !load_n && rw};
    for (int ph = 0; ph < 16; ph++) begin
      @(posedge i_sys_clk);
      case (ph)
        0: begin
          o_k <= 1'b1;
          o_k_n <= 1'b0;
          o_load_select_n <= load_n;
          o_rw <= rw;
          o_addr <= a;
          o_d <= pend ? pend_d0 : ~o_d; // idle data keeps toggling
          o_byte_lane_write_n <= pend ? pend_m0 : 4'hf;
        end
        2: begin
          o_c <= 1'b1;
          o_c_n <= 1'b0;
        end
        8: begin
          o_k <= 1'b0;
          o_k_n <= 1'b1;
          o_d <= pend ? pend_d1 : ~o_d;
          o_byte_lane_write_n <= pend ? pend_m1 : 4'hf;
        end
        10: begin
          o_c <= 1'b0;
          o_c_n <= 1'b1;
        end
        default: ;
      endcase
      // sample well after the output edge so the word has settled
      @(negedge i_sys_clk);
      if ((ph == 7 && r2) || (ph == 15 && r1)) begin
        rdq.push_back({i_q_oe, i_q});
      end
    end
    pend = !load_n && !rw;
    {pend_d0, pend_m0, pend_d1, pend_m1} = {d0, m0, d1, m1};
  endtask : cmd

  // every pin held where it is; no edge reaches the port
  task automatic stop(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : stop
endmodule : ddrsp_ctrl_model

// ===== verif/ddrsp_port_tb_top.sv
/*
  Self-checking bench for the burst SRAM port at the default x18 width.
  Assumes the controller model in ddrsp_ctrl_model and the package ddrsp_pkg.
*/
module ddrsp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = ddrsp_pkg::DATA_W_DEFAULT;
  localparam int AW = ddrsp_pkg::ADDR_W_DEFAULT;
  logic          i_sys_clk, i_nrst, k, k_n, c, c_n, load_n, rw, q_oe;
  logic [AW-1:0] addr;
  logic [DW-1:0] d, q;
  logic [3:0]    sel;
  int            errors, n_checks;

  ddrsp_port dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_k(k), .i_k_n(k_n), .i_c(c),
    .i_c_n(c_n), .i_load_select_n(load_n), .i_rw(rw), .i_addr(addr), .i_d(d),
    .i_byte_lane_write_n(sel), .o_q(q), .o_q_oe(q_oe));
  ddrsp_ctrl_model #(.DATA_W(DW), .ADDR_W(AW)) ctrl (.i_sys_clk(i_sys_clk), .i_q(q),
    .i_q_oe(q_oe), .o_k(k), .o_k_n(k_n), .o_c(c), .o_c_n(c_n), .o_load_select_n(load_n),
    .o_rw(rw), .o_addr(addr), .o_d(d), .o_byte_lane_write_n(sel));

  always #5 i_sys_clk = ~i_sys_clk;

  task automatic chk(input string name, input logic [DW:0] exp, input logic [DW:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // next captured read word must be driven with the enable high
  task automatic word(input logic [DW-1:0] exp);
    logic [DW:0] got;
    got = 'x;
    if (ctrl.rdq.size() > 0) got = ctrl.rdq.pop_front();
    chk("read word", {1'b1, exp}, got);
  endtask : word

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0, input logic [3:0] m0,
                    input logic [DW-1:0] d1, input logic [3:0] m1);
    ctrl.cmd(1'b0, 1'b0, a, d0, m0, d1, m1);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    ctrl.cmd(1'b0, 1'b1, a, '0, 4'hf, '0, 4'hf);
  endtask : rd

  task automatic nop(input logic rw_x);
    ctrl.cmd(1'b1, rw_x, '0, '0, 4'hf, '0, 4'hf);
  endtask : nop

  // read straight after a write hits the posted data, words in burst order
  task automatic t_write_read();
    wr(4'h3, 18'h12345, 4'hc, 18'h2abcd, 4'hc);
    rd(4'h3);
    nop(1'b0);
    nop(1'b0);
    word(18'h12345);
    word(18'h2abcd);
    $display("test write_read done");
  endtask : t_write_read

  // per-word masks differ within one write; an all-high write changes nothing
  task automatic t_lanes();
    wr(4'h5, 18'h00000, 4'hc, 18'h00000, 4'hc);
    wr(4'h5, 18'h3ffff, 4'he, 18'h3ffff, 4'hd);
    wr(4'h5, 18'h3ffff, 4'hf, 18'h3ffff, 4'hf);
    wr(4'h9, 18'h00001, 4'hc, 18'h00002, 4'hc);
    rd(4'h5);
    rd(4'h9);
    nop(1'b0);
    nop(1'b0);
    word(18'h001ff);
    word(18'h3fe00);
    word(18'h00001);
    word(18'h00002);
    $display("test lanes done");
  endtask : t_lanes

  // commands on every strobe, write squeezed between reads
  task automatic t_b2b();
    wr(4'h6, 18'h11111, 4'hc, 18'h22222, 4'hc);
    wr(4'h7, 18'h33333, 4'hc, 18'h04444, 4'hc);
    rd(4'h7);
    wr(4'h6, 18'h05555, 4'hc, 18'h06666, 4'hc);
    rd(4'h6);
    nop(1'b0);
    nop(1'b0);
    word(18'h33333);
    word(18'h04444);
    word(18'h05555);
    word(18'h06666);
    $display("test back_to_back done");
  endtask : t_b2b

  // burst finishes, then the outputs float; rw is ignored on a no-op
  task automatic t_nop();
    rd(4'h3);
    nop(1'b0);
    nop(1'b0);
    chk("enable during burst", {1'b1, 18'h2abcd}, {q_oe, q});
    nop(1'b1);
    chk("idle outputs", {1'b0, 18'h2abcd}, {q_oe, q});
    nop(1'b1);
    chk("words queued", (DW+1)'(2), (DW+1)'(ctrl.rdq.size()));
    word(18'h12345);
    word(18'h2abcd);
    $display("test nop done");
  endtask : t_nop

  // strobes stop in mid-burst; outputs hold and the burst resumes afterwards
  task automatic t_stop();
    logic [DW:0] held;
    rd(4'h3);
    nop(1'b0);
    held = {q_oe, q};
    chk("first word", {1'b1, 18'h12345}, held);
    ctrl.stop(48);
    @(negedge i_sys_clk);
    chk("outputs while stopped", held, {q_oe, q});
    nop(1'b0);
    word(18'h12345);
    word(18'h2abcd);
    $display("test stop done");
  endtask : t_stop

  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    i_sys_clk = 1'b0;
    i_nrst = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("outputs after reset", '0, {q_oe, q});
    $display("test reset done");
    t_write_read();
    t_lanes();
    t_b2b();
    t_nop();
    t_stop();
    results();
  end

  // hang guard, far beyond the roughly 30 strobe cycles of the run
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    errors++;
    $display("watchdog ran out");
    results();
  end
endmodule : ddrsp_port_tb_top
